// ==== design/apd_pkg.sv ====
/*
 Package for the automatic power-down manager: field positions, reset
 values, timing counts and the grouped signal structs.
 Assumes a single 100 MHz clock domain and an async active-high reset.
*/
// How it works
// [R1] Idle counter starts when strobe activity stops
// [R2] Fifteen idle clocks raise powerdown flag
// [R3] Enabling the unit alone enables power-down
// [R4] Strobe pulsing again ends power-down
// [R5] Chip-select low or reset ends power-down
// [R6] Power-down blocks address and data paths
// [R7] Power-down deselects all memories internally
// [R8] Aux clock always reaches the idle counter
// [R9] Power-down leaves logic and ports running
// [R10] Ports hold, address undefined, data tri-stated
// [R11] Chip-select high disables memories only
// [R12] Memories wake on input change, then standby
// [R13] Full-speed logic defaults on; bit turns off
// [R14] Blocking bits gate signals to both arrays
// [R15] Mode register A bit 1 enables unit
// [R16] Mode register A bit 3 is full-speed off
// [R17] Mode register B bits 2-6 block inputs
// [R18] Mode registers clear at power-up only
// [R19] Strobe edge clears counter; holds at terminal
// [R20] Disabled unit holds counter clear, flag low
package apd_pkg;
   localparam int MODE_W = 8;
   localparam int BIT_APD_EN = 1;
   localparam int BIT_TURBO_OFF = 3;
   localparam int BIT_ARRAY_CLK_OFF = 4;
   localparam int BIT_MCELL_CLK_OFF = 5;
   localparam int BIT_BLK_CTL0 = 2;
   localparam int BIT_BLK_CTL1 = 3;
   localparam int BIT_BLK_CTL2 = 4;
   localparam int BIT_BLK_ALE = 5;
   localparam int BIT_BLK_DBE = 6;
   localparam logic [7:0] MODE_A_RESET = 8'h00;
   localparam logic [7:0] MODE_B_RESET = 8'h00;
   localparam logic [7:0] MODE_A_MASK = 8'h3A;
   localparam logic [7:0] MODE_B_MASK = 8'h7C;
   localparam int IDLE_W = 4;
   localparam logic [3:0] IDLE_TERMINAL = 4'hF;
   localparam logic [3:0] IDLE_ZERO = 4'h0;

   typedef struct packed {
      logic ctl0;
      logic ctl1;
      logic ctl2;
      logic ale;
      logic dbe;
      logic clkArray;
      logic clkMcell;
   } array_in_s;

   typedef struct packed {
      logic flashSel;
      logic sramSel;
      logic ioSel;
      logic busPass;
   } mem_sel_s;
endpackage

// ==== design/auto_power_down_manager.sv ====
/*
 Automatic power-down manager: idle watchdog on the address latch strobe,
 power-down gating of the MCU bus to memories and logic arrays, chip-select
 handling, full-speed control and array input blocking bits.
 Assumes strobe, aux clock, chip-select, byte-enable and control pins arrive asynchronously on ref_clk and are synchronised
 here; the aux clock input is sampled as an ordinary input.
*/
module auto_power_down_manager (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic powerUp,
   input wire logic addrLatchStrobe,
   input wire logic auxClockInput,
   input wire logic chipSelectN,
   input wire logic byteEnableIn,
   input wire logic [2:0] busCtlIn,
   input wire logic modeAWrite,
   input wire logic modeBWrite,
   input wire logic [7:0] modeWData,
   input wire logic [7:0] portOutLevel,
   input wire logic [7:0] portOutEnIn,
   input wire logic [7:0] dataPortEnIn,
   output logic powerdownFlag,
   output logic [7:0] modeARead,
   output logic [7:0] modeBRead,
   output logic turboOn,
   output apd_pkg::array_in_s arrayIn,
   output apd_pkg::mem_sel_s memSel,
   output logic [7:0] portLevel,
   output logic [7:0] portOutEn,
   output logic [7:0] dataPortEn
);
   // Pin synchronisers: stage 1 feeds stage 2 only
   logic [6:0] syncA_reg;
   logic [6:0] syncB_reg;
   logic [6:0] pinsRaw;
   logic asS, clkS, csnS, dbeS;
   logic [2:0] ctlS;
   logic asPrev_reg, clkPrev_reg;
   logic asEdge, clkRise;

   assign pinsRaw = {addrLatchStrobe, auxClockInput, chipSelectN,
                     byteEnableIn, busCtlIn};

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         syncA_reg <= 7'h00;
         syncB_reg <= 7'h00;
         asPrev_reg <= 1'b0;
         clkPrev_reg <= 1'b0;
      end else begin
         syncA_reg <= pinsRaw;
         syncB_reg <= syncA_reg;
         asPrev_reg <= syncB_reg[6];
         clkPrev_reg <= syncB_reg[5];
      end
   end

   assign asS = syncB_reg[6];
   assign clkS = syncB_reg[5];
   assign csnS = syncB_reg[4];
   assign dbeS = syncB_reg[3];
   assign ctlS = syncB_reg[2:0];
   assign asEdge = asS ^ asPrev_reg;
   // Counter sees the aux clock regardless of array clock blocking
   assign clkRise = clkS & ~clkPrev_reg; // [R8]

   // Mode registers: cleared only by power-up, not by reset
   logic [7:0] modeA_reg, modeA_next;
   logic [7:0] modeB_reg, modeB_next;

   always_comb begin
      modeA_next = modeA_reg;
      modeB_next = modeB_reg;
      if (modeAWrite) begin // [R14]
         modeA_next = modeWData & apd_pkg::MODE_A_MASK;
      end
      if (modeBWrite) begin // [R14]
         modeB_next = modeWData & apd_pkg::MODE_B_MASK;
      end
   end

   always_ff @(posedge ref_clk or posedge powerUp) begin
      if (powerUp) begin
         modeA_reg <= apd_pkg::MODE_A_RESET; // [R18]
         modeB_reg <= apd_pkg::MODE_B_RESET; // [R18]
      end else begin
         modeA_reg <= modeA_next;
         modeB_reg <= modeB_next;
      end
   end

   logic apdEnable;
   assign apdEnable = modeA_reg[apd_pkg::BIT_APD_EN]; // [R15] [R3]

   // Power state machine
   typedef enum logic [1:0] {
      RUN = 2'b01,
      DOWN = 2'b10
   } pwr_state_e;

   pwr_state_e state_reg, state_next;
   logic [3:0] idle_reg, idle_next;

   always_comb begin
      state_next = state_reg;
      idle_next = idle_reg;
      case (state_reg)
         RUN: begin
            if (!apdEnable || asEdge) begin
               idle_next = apd_pkg::IDLE_ZERO; // [R19] [R20] [R1]
            end else if (clkRise) begin
               idle_next = idle_reg + 4'h1; // [R1]
               if (idle_reg + 4'h1 == apd_pkg::IDLE_TERMINAL) begin
                  state_next = DOWN; // [R2]
               end
            end
         end
         DOWN: begin
            if (!apdEnable) begin
               state_next = RUN; // [R20]
               idle_next = apd_pkg::IDLE_ZERO;
            end else if (asEdge || !csnS) begin
               state_next = RUN; // [R4] [R5]
               idle_next = apd_pkg::IDLE_ZERO; // [R19]
            end else begin
               idle_next = apd_pkg::IDLE_TERMINAL; // [R19]
            end
         end
         default: begin
            state_next = RUN;
            idle_next = apd_pkg::IDLE_ZERO;
         end
      endcase
   end

   // Reset forces the running state; mode registers survive it
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_reg <= RUN; // [R5]
         idle_reg <= apd_pkg::IDLE_ZERO;
      end else begin
         state_reg <= state_next;
         idle_reg <= idle_next;
      end
   end

   // Next state, not current: outputs then change on the same edge as the
   // state itself, so the flag and the gating never disagree
   logic down;
   assign down = (state_next == DOWN);

   // Pass a pin into the logic arrays unless its blocking bit is set
   function automatic logic gateIn(input logic pin, input logic blockBit);
      gateIn = pin & ~blockBit;
   endfunction

   // A memory is selected only with chip-select low and the part awake
   function automatic logic memEnable(input logic csnLow, input logic dn);
      memEnable = csnLow & ~dn;
   endfunction

   // Array inputs: the logic keeps running in power-down; only the strobe
   // is cut there, since it belongs to the blocked MCU bus path
   apd_pkg::array_in_s arrayIn_next;

   always_comb begin
      arrayIn_next.ctl0 = gateIn(ctlS[0],
         modeB_reg[apd_pkg::BIT_BLK_CTL0]); // [R17]
      arrayIn_next.ctl1 = gateIn(ctlS[1],
         modeB_reg[apd_pkg::BIT_BLK_CTL1]); // [R17]
      arrayIn_next.ctl2 = gateIn(ctlS[2],
         modeB_reg[apd_pkg::BIT_BLK_CTL2]); // [R17]
      arrayIn_next.ale = gateIn(asS,
         modeB_reg[apd_pkg::BIT_BLK_ALE]) & ~down; // [R6] [R17]
      arrayIn_next.dbe = gateIn(dbeS,
         modeB_reg[apd_pkg::BIT_BLK_DBE]); // [R17]
      arrayIn_next.clkArray = gateIn(clkS,
         modeA_reg[apd_pkg::BIT_ARRAY_CLK_OFF]); // [R14]
      arrayIn_next.clkMcell = gateIn(clkS,
         modeA_reg[apd_pkg::BIT_MCELL_CLK_OFF]); // [R9]
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         arrayIn <= '0;
      end else begin
         arrayIn <= arrayIn_next;
      end
   end

   // Memory selects: memories idle in standby on their own, so the select
   // only decides whether bus changes may wake them
   apd_pkg::mem_sel_s memSel_next;

   always_comb begin
      memSel_next.flashSel = memEnable(~csnS, down); // [R7] [R11] [R12]
      memSel_next.sramSel = memEnable(~csnS, down); // [R7] [R11]
      memSel_next.ioSel = memEnable(~csnS, down); // [R11]
      memSel_next.busPass = ~down; // [R6]
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         memSel <= '0;
      end else begin
         memSel <= memSel_next;
      end
   end

   // Port pins: I/O and logic-output pins keep their levels; address-out
   // is don't-care, so it simply follows; data port lets go
   logic [7:0] portLevel_next;
   logic [7:0] portOutEn_next;
   logic [7:0] dataPortEn_next;

   always_comb begin
      portLevel_next = portOutLevel; // [R9] [R10]
      portOutEn_next = portOutEnIn; // [R10]
      dataPortEn_next = down ? 8'h00 : dataPortEnIn; // [R10]
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         portLevel <= 8'h00;
         portOutEn <= 8'h00;
         dataPortEn <= 8'h00;
      end else begin
         portLevel <= portLevel_next;
         portOutEn <= portOutEn_next;
         dataPortEn <= dataPortEn_next;
      end
   end

   // Status: flag, full-speed control and mode readback. Readback shows
   // zero while reset is held although the registers keep their contents
   logic powerdownFlag_next;
   logic turboOn_next;
   logic [7:0] modeARead_next;
   logic [7:0] modeBRead_next;

   always_comb begin
      powerdownFlag_next = down; // [R2]
      turboOn_next = ~modeA_reg[apd_pkg::BIT_TURBO_OFF]; // [R13] [R16]
      modeARead_next = modeA_reg;
      modeBRead_next = modeB_reg;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         powerdownFlag <= 1'b0;
         turboOn <= 1'b1;
         modeARead <= 8'h00;
         modeBRead <= 8'h00;
      end else begin
         powerdownFlag <= powerdownFlag_next;
         turboOn <= turboOn_next;
         modeARead <= modeARead_next;
         modeBRead <= modeBRead_next;
      end
   end
endmodule

// ==== verif/apd_checker.sv ====
/* Port assertions for the power-down manager.
   Assumes it is bound into auto_power_down_manager on ref_clk. */
module apd_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic addrLatchStrobe,
   input wire logic chipSelectN,
   input wire logic [7:0] portOutLevel,
   input wire logic powerdownFlag,
   input wire logic [7:0] modeARead,
   input wire logic [7:0] modeBRead,
   input wire apd_pkg::array_in_s arrayIn,
   input wire apd_pkg::mem_sel_s memSel,
   input wire logic [7:0] portLevel,
   input wire logic [7:0] dataPortEn
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_sel_down: assert property (powerdownFlag |-> memSel == 4'h0)
      else $error("memories selected in power-down");
   a_data_tristate: assert property (powerdownFlag |-> !dataPortEn)
      else $error("data port driven in power-down");
   a_ale_blocked: assert property (powerdownFlag && $past(powerdownFlag)
      |-> !arrayIn.ale)
      else $error("strobe reached arrays in power-down");
   a_disabled_idle: assert property (!modeARead[1] ##1 !modeARead[1]
      |-> !powerdownFlag)
      else $error("flag high with unit disabled");
   a_csn_wakes: assert property (powerdownFlag && !chipSelectN
      |-> ##[1:4] !powerdownFlag)
      else $error("no wake on chip-select low");
   a_strobe_wakes: assert property (powerdownFlag && $changed(addrLatchStrobe)
      |-> ##[1:5] !powerdownFlag)
      else $error("no wake on strobe activity");
   a_ctl0_block: assert property (modeBRead[2] && $past(modeBRead[2])
      |-> !arrayIn.ctl0)
      else $error("blocked control line passed");
   a_mode_masked: assert property (!(modeARead & ~apd_pkg::MODE_A_MASK)
      && !(modeBRead & ~apd_pkg::MODE_B_MASK))
      else $error("unused mode bit set");
   a_port_hold: assert property (!$past(reset)
      |-> portLevel == $past(portOutLevel))
      else $error("port level altered");
endmodule
bind auto_power_down_manager apd_checker apd_checker_i (.ref_clk, .reset,
   .addrLatchStrobe, .chipSelectN, .portOutLevel, .powerdownFlag,
   .modeARead, .modeBRead, .arrayIn, .memSel, .portLevel, .dataPortEn);

// ==== verif/mcu_bus_model.sv ====
/* MCU side: address strobe while busy, free-running aux oscillator.
   Assumes a 100 MHz ref_clk; outputs change on its falling edge. */
module mcu_bus_model (
   input wire logic ref_clk,
   input wire logic busy,
   output logic addrLatchStrobe,
   output logic auxClockInput
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   initial addrLatchStrobe = 1'b0;
   initial auxClockInput = 1'b0;
   // Six-cycle oscillator: 15 periods far exceed the 4-cycle strobe period, so no false sleep
   always @(negedge ref_clk) begin
      n <= n + 1;
      if (n % 3 == 2) auxClockInput <= ~auxClockInput;
      if (busy && n % 2 == 0) addrLatchStrobe <= ~addrLatchStrobe;
   end
endmodule

// ==== verif/auto_power_down_manager_tb.sv ====
/* Self-checking bench for the power-down manager.
   Assumes the MCU model makes strobe and aux clock. */
module auto_power_down_manager_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, reset = 1'b1, powerUp = 1'b1, busy = 1'b1;
   logic chipSelectN = 1'b1, byteEnableIn = 1'b1, modeAWrite = 1'b0;
   logic modeBWrite = 1'b0, addrLatchStrobe, auxClockInput;
   logic powerdownFlag, turboOn;
   logic [2:0] busCtlIn = 3'h7;
   logic [7:0] modeWData = 8'h00, portOutLevel = 8'hA5, portOutEnIn = 8'h3C;
   logic [7:0] dataPortEnIn = 8'hFF, modeARead, modeBRead, portLevel;
   logic [7:0] portOutEn, dataPortEn;
   apd_pkg::array_in_s arrayIn;
   apd_pkg::mem_sel_s memSel;
   int nFail = 0, comparisons = 0, t;
   auto_power_down_manager auto_power_down_manager_i (.ref_clk, .reset,
      .powerUp, .addrLatchStrobe, .auxClockInput, .chipSelectN,
      .byteEnableIn, .busCtlIn, .modeAWrite, .modeBWrite, .modeWData,
      .portOutLevel, .portOutEnIn, .dataPortEnIn, .powerdownFlag,
      .modeARead, .modeBRead, .turboOn, .arrayIn, .memSel, .portLevel,
      .portOutEn, .dataPortEn);
   mcu_bus_model mcu_bus_model_i (.ref_clk, .busy, .addrLatchStrobe,
      .auxClockInput);
   initial forever #5 ref_clk = ~ref_clk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         nFail++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic closeOut();
      $display("comparisons %0d mismatches %0d", comparisons, nFail);
      if (nFail == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge ref_clk);
   endtask
   task automatic wr(input logic b, input logic [7:0] d);
      modeWData = d;
      modeAWrite = !b;
      modeBWrite = b;
      cyc(1);
      modeAWrite = 1'b0;
      modeBWrite = 1'b0;
      cyc(2);
   endtask
   // Bounded wait for the flag; running out ends the run as a failure
   task automatic waitFlag(input logic v, input int lim);
      t = 0;
      while (powerdownFlag !== v && t < lim) begin
         cyc(1);
         t++;
      end
      if (t >= lim) begin
         nFail++;
         closeOut();
      end
   endtask
   task automatic tModes();
      check(modeARead, 8'h00);
      check(turboOn, 1'b1);
      wr(1'b0, 8'hFF);
      check(modeARead, 8'h3A);
      check(turboOn, 1'b0);
      wr(1'b1, 8'hFF);
      check(modeBRead, 8'h7C);
      check(arrayIn, 7'h00);
      wr(1'b1, 8'h00);
      check(arrayIn[6:4], 3'h7);
      check(arrayIn.dbe, 1'b1);
      $display("tModes done");
   endtask
   task automatic tIdle();
      wr(1'b0, 8'h32);
      busy = 1'b0;
      waitFlag(1'b1, 200);
      check(t >= 80 && t <= 100, 1'b1);
      check(memSel, 4'h0);
      check(dataPortEn, 8'h00);
      check(portLevel, 8'hA5);
      check(portOutEn, 8'h3C);
      busy = 1'b1;
      waitFlag(1'b0, 8);
      check(dataPortEn, 8'hFF);
      busy = 1'b0;
      waitFlag(1'b1, 200);
      chipSelectN = 1'b0;
      waitFlag(1'b0, 8);
      check(memSel, 4'hF);
      busy = 1'b1;
      chipSelectN = 1'b1;
      cyc(4);
      check(memSel, 4'h1);
      $display("tIdle done");
   endtask
   task automatic tResetWake();
      busy = 1'b0;
      waitFlag(1'b1, 200);
      reset = 1'b1;
      cyc(2);
      reset = 1'b0;
      cyc(1);
      check(powerdownFlag, 1'b0);
      cyc(1);
      check(modeARead, 8'h32);
      wr(1'b0, 8'h00);
      cyc(150);
      check(powerdownFlag, 1'b0);
      busy = 1'b1;
      $display("tResetWake done");
   endtask
   initial begin
      cyc(12);
      reset = 1'b0;
      powerUp = 1'b0;
      cyc(1);
      tModes();
      tIdle();
      tResetWake();
      closeOut();
   end
endmodule
